// ===== hw/csf_flag_calc.sv
/*
  Combinational result and flag calculation for one ALU operation.
  Assumes operands are stable for the cycle; only bits 7..2 of flags are meaningful.
*/
`timescale 1ns/1ns
`default_nettype none
module csf_flag_calc
(
  csf_alu_if.calc alu
);
  logic [8:0] wide;
  logic [4:0] nib;
  logic       ci;
  logic       isSub;
  logic       isArith;

  always_comb
  begin
    ci      = (alu.op == csf_pkg::CSF_OP_ADC || alu.op == csf_pkg::CSF_OP_SBC) ? alu.carryIn : 1'b0;
    isSub   = (alu.op == csf_pkg::CSF_OP_SUB || alu.op == csf_pkg::CSF_OP_SBC);
    isArith = isSub || alu.op == csf_pkg::CSF_OP_ADD || alu.op == csf_pkg::CSF_OP_ADC;
    wide    = 9'h000;
    nib     = 5'h00;
    case (alu.op)
      csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADC:
      begin
        wide = {1'b0, alu.opA} + {1'b0, alu.opB} + {8'h00, ci};
        nib  = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]} + {4'h0, ci};
      end
      csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SBC:
      begin
        wide = {1'b0, alu.opA} - {1'b0, alu.opB} - {8'h00, ci};
        nib  = {1'b0, alu.opA[3:0]} - {1'b0, alu.opB[3:0]} - {4'h0, ci};
      end
      csf_pkg::CSF_OP_AND: wide = {1'b0, alu.opA & alu.opB};
      csf_pkg::CSF_OP_OR:  wide = {1'b0, alu.opA | alu.opB};
      csf_pkg::CSF_OP_XOR: wide = {1'b0, alu.opA ^ alu.opB};
      default:             wide = {1'b0, alu.opA};
    endcase
  end

  assign alu.result = wide[7:0];

  always_comb
  begin
    alu.flags = 8'h00;
    alu.flags[csf_pkg::BIT_CARRY]  = isArith & wide[8];
    alu.flags[csf_pkg::BIT_ZERO]   = (wide[7:0] == 8'h00);
    alu.flags[csf_pkg::BIT_SIGN]   = wide[7];
    alu.flags[csf_pkg::BIT_OVFL]   = isArith & ((alu.opA[7] ^ alu.opB[7]) == isSub)
                                     & (wide[7] != alu.opA[7]);
    alu.flags[csf_pkg::BIT_DECADJ] = isSub;
    alu.flags[csf_pkg::BIT_HALF]   = isArith & nib[4];
  end
endmodule : csf_flag_calc
`default_nettype wire

// ===== hw/csf_status_flags.sv
/*
  Processor status flag register with datapath and register-addressed access.
  Assumes the core issues one ALU update and one register access per cycle on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module csf_status_flags
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  input  wire logic [7:0]             regWrData,
  output logic      [7:0]             regRdData,
  input  wire logic                   aluValid,
  input  wire csf_pkg::csf_op_e       aluOp,
  input  wire logic [7:0]             aluA,
  input  wire logic [7:0]             aluB,
  input  wire logic [5:0]             aluAffect,
  output logic      [7:0]             aluResult,
  input  wire logic                   fastIrqEnter,
  input  wire logic                   irqReturnStart,
  output logic      [7:0]             flags
);
  logic [7:0] flags_q;
  logic [7:0] rdData_q;
  logic [7:0] result_q;
  logic       wrHit;
  logic       rdHit;

  csf_alu_if aluIf ();

  //////////////////////////////////////////////////////////////////////
  // Datapath hookup
  assign aluIf.op      = aluOp;
  assign aluIf.opA     = aluA;
  assign aluIf.opB     = aluB;
  assign aluIf.carryIn = flags_q[csf_pkg::BIT_CARRY];

  csf_flag_calc u_calc
  (
    .alu (aluIf.calc)
  );

  //////////////////////////////////////////////////////////////////////
  // Address decode
  // fixed address match
  assign wrHit = regWr && (regAddr == csf_pkg::FLAGS_ADDR);
  assign rdHit = regRd && (regAddr == csf_pkg::FLAGS_ADDR);

  //////////////////////////////////////////////////////////////////////
  // Arithmetic flags, bits 7..2
  generate
    for (genvar i = csf_pkg::ALU_LSB; i < 8; i++)
    begin : g_flag
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          flags_q[i] <= csf_pkg::FLAGS_RESET[i];
        end
        else if (wrHit)
        begin
          flags_q[i] <= regWrData[i];
        end
        else if (aluValid && aluAffect[i-csf_pkg::ALU_LSB])
        begin
          flags_q[i] <= aluIf.flags[i];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Fast interrupt status, read-only
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_q[csf_pkg::BIT_FASTIRQ] <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_FASTIRQ];
    end
    else if (fastIrqEnter)
    begin
      flags_q[csf_pkg::BIT_FASTIRQ] <= 1'b1;
    end
    else if (irqReturnStart)
    begin
      flags_q[csf_pkg::BIT_FASTIRQ] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bank select
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_q[csf_pkg::BIT_BANK] <= csf_pkg::FLAGS_RESET[csf_pkg::BIT_BANK];
    end
    else if (wrHit)
    begin
      flags_q[csf_pkg::BIT_BANK] <= regWrData[csf_pkg::BIT_BANK];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read port and result
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdData_q <= csf_pkg::RD_UNMAPPED;
    end
    else if (rdHit)
    begin
      rdData_q <= flags_q;
    end
    else if (regRd)
    begin
      rdData_q <= csf_pkg::RD_UNMAPPED;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_q <= 8'h00;
    end
    else if (aluValid)
    begin
      result_q <= aluIf.result;
    end
  end

  assign regRdData = rdData_q;
  assign aluResult = result_q;
  assign flags     = flags_q;

  //////////////////////////////////////////////////////////////////////
  // Checks
  logic aluC;
  logic aluV;
  logic aluH;
  logic [8:0] subW;
  logic [4:0] subN;
  logic [7:0] addS;
  always_comb
  begin
    subW = {1'b0, aluA} - {1'b0, aluB};
    subN = {1'b0, aluA[3:0]} - {1'b0, aluB[3:0]};
    addS = aluA + aluB;
    aluC = subW[8];
    aluH = subN[4];
    aluV = (aluA[7] == aluB[7]) && (addS[7] != aluA[7]);
  end

  sequence s_upd(int b);
    aluValid && !wrHit && aluAffect[b-csf_pkg::ALU_LSB];
  endsequence

  property p_carry;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(7) ##0 (aluOp == csf_pkg::CSF_OP_SUB) |=> flags_q[7] == $past(aluC);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");

  property p_zero;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(6) |=> flags_q[6] == (result_q == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero wrong");

  property p_sign;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(5) |=> flags_q[5] == result_q[7];
  endproperty
  a_sign: assert property (p_sign) else $error("sign wrong");

  property p_ovfl;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(4) ##0 (aluOp == csf_pkg::CSF_OP_ADD) ##0
      (aluA == 8'h7F) ##0 (aluB == 8'h01) |=> flags_q[4] && result_q == csf_pkg::SIGN_MIN;
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow wrong");

  property p_ovfl_add;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(4) ##0 (aluOp == csf_pkg::CSF_OP_ADD) |=> flags_q[4] == $past(aluV);
  endproperty
  a_ovfl_add: assert property (p_ovfl_add) else $error("add overflow wrong");

  property p_decadj;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(3) |=> flags_q[3] == $past(aluOp == csf_pkg::CSF_OP_SUB
                                     || aluOp == csf_pkg::CSF_OP_SBC);
  endproperty
  a_decadj: assert property (p_decadj) else $error("decimal adjust wrong");

  property p_half;
    @(posedge core_clk) disable iff (!rst_b)
    s_upd(2) ##0 (aluOp == csf_pkg::CSF_OP_SUB) |=> flags_q[2] == $past(aluH);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_fastirq;
    @(posedge core_clk) disable iff (!rst_b)
    !fastIrqEnter && !irqReturnStart |=> $stable(flags_q[1]);
  endproperty
  a_fastirq: assert property (p_fastirq) else $error("fast irq flag moved");

  property p_fastirq_set;
    @(posedge core_clk) disable iff (!rst_b)
    fastIrqEnter |=> flags_q[csf_pkg::BIT_FASTIRQ];
  endproperty
  a_fastirq_set: assert property (p_fastirq_set) else $error("fast irq entry lost");

  property p_bank;
    @(posedge core_clk) disable iff (!rst_b)
    wrHit |=> flags_q[0] == $past(regWrData[0]) ##1 (flags_q[0] == $past(flags_q[0]) || $past(wrHit));
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");

  property p_read;
    @(posedge core_clk) disable iff (!rst_b)
    regRd && regAddr != csf_pkg::FLAGS_ADDR |=> regRdData == csf_pkg::RD_UNMAPPED;
  endproperty
  a_read: assert property (p_read) else $error("unmapped read not zero");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
    !wrHit && !aluValid |=> $stable(flags_q[7:2]);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed without cause");

  property p_wr_wins;
    @(posedge core_clk) disable iff (!rst_b)
    wrHit |=> flags_q[7:2] == $past(regWrData[7:2]);
  endproperty
  a_wr_wins: assert property (p_wr_wins) else $error("write did not land");
endmodule : csf_status_flags
`default_nettype wire

// ===== inc/csf_alu_if.sv
/*
  Carrier between the flag register and its flag calculator.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface csf_alu_if;
  csf_pkg::csf_op_e op;
  logic [7:0]       opA;
  logic [7:0]       opB;
  logic             carryIn;
  logic [7:0]       result;
  logic [7:0]       flags;

  modport core (output op, output opA, output opB, output carryIn,
                input result, input flags);
  modport calc (input op, input opA, input opB, input carryIn,
                output result, output flags);
endinterface : csf_alu_if
`default_nettype wire

// ===== inc/csf_pkg.sv
/*
  Constants for the processor status flag register.
  Assumes a single core clock and an 8-bit register address space.
*/
`default_nettype none
package csf_pkg;
  // Register address in the upper system register set
  localparam logic [7:0] FLAGS_ADDR  = 8'hD5;
  // Bit positions
  localparam int         BIT_CARRY   = 7;
  localparam int         BIT_ZERO    = 6;
  localparam int         BIT_SIGN    = 5;
  localparam int         BIT_OVFL    = 4;
  localparam int         BIT_DECADJ  = 3;
  localparam int         BIT_HALF    = 2;
  localparam int         BIT_FASTIRQ = 1;
  localparam int         BIT_BANK    = 0;
  // Lowest bit written by the datapath
  localparam int         ALU_LSB     = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] SIGN_MIN    = 8'h80;

  typedef enum logic [2:0]
  {
    CSF_OP_ADD  = 3'h0,
    CSF_OP_ADC  = 3'h1,
    CSF_OP_SUB  = 3'h3,
    CSF_OP_SBC  = 3'h2,
    CSF_OP_AND  = 3'h6,
    CSF_OP_OR   = 3'h7,
    CSF_OP_XOR  = 3'h5,
    CSF_OP_PASS = 3'h4
  } csf_op_e;
endpackage : csf_pkg
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the processor status flag register.
  Assumes the block at csf_status_flags with one core clock and async low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check8(g, e)
module tb_top;
  logic             core_clk;
  logic             rst_b;
  logic [7:0]       regAddr;
  logic             regWr;
  logic             regRd;
  logic [7:0]       regWrData;
  logic [7:0]       regRdData;
  logic             aluValid;
  csf_pkg::csf_op_e aluOp;
  logic [7:0]       aluA;
  logic [7:0]       aluB;
  logic [5:0]       aluAffect;
  logic [7:0]       aluResult;
  logic             fastIrqEnter;
  logic             irqReturnStart;
  logic [7:0]       flags;
  int               fails;
  int               samples_checked;

  csf_status_flags u_dut (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
    .aluValid(aluValid), .aluOp(aluOp), .aluA(aluA), .aluB(aluB),
    .aluAffect(aluAffect), .aluResult(aluResult), .fastIrqEnter(fastIrqEnter),
    .irqReturnStart(irqReturnStart), .flags(flags));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr     <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1;
    `CHK(regRdData, e);
  endtask : rd

  task automatic alu(input csf_pkg::csf_op_e o, input logic [7:0] a, input logic [7:0] b,
                     input logic [5:0] m, input logic [7:0] r, input logic [7:0] f);
    @(posedge core_clk);
    aluOp     <= o;
    aluA      <= a;
    aluB      <= b;
    aluAffect <= m;
    aluValid  <= 1'b1;
    @(posedge core_clk);
    aluValid  <= 1'b0;
    #1;
    `CHK(aluResult, r);
    `CHK(flags, f);
  endtask : alu

  task automatic finish_test;
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_regs;
    `CHK(flags, csf_pkg::FLAGS_RESET);
    wr(csf_pkg::FLAGS_ADDR, 8'hFF);
    `CHK(flags, 8'hFD);
    rd(csf_pkg::FLAGS_ADDR, 8'hFD);
    wr(8'hD4, 8'h00);
    `CHK(flags, 8'hFD);
    rd(8'hD4, csf_pkg::RD_UNMAPPED);
    wr(csf_pkg::FLAGS_ADDR, 8'h00);
    `CHK(flags, 8'h00);
    wr(csf_pkg::FLAGS_ADDR, 8'h01);
    `CHK(flags, 8'h01);
    $display("test regs done");
  endtask : test_regs

  task automatic test_arith;
    alu(csf_pkg::CSF_OP_ADD, 8'h7F, 8'h01, 6'h3F, 8'h80, 8'h35);
    alu(csf_pkg::CSF_OP_SUB, 8'h00, 8'h01, 6'h3F, 8'hFF, 8'hAD);
    alu(csf_pkg::CSF_OP_ADD, 8'hFF, 8'h01, 6'h3F, 8'h00, 8'hC5);
    alu(csf_pkg::CSF_OP_ADC, 8'h00, 8'h00, 6'h3F, 8'h01, 8'h01);
    alu(csf_pkg::CSF_OP_AND, 8'hF0, 8'h0F, 6'h3F, 8'h00, 8'h41);
    alu(csf_pkg::CSF_OP_SUB, 8'h80, 8'h01, 6'h00, 8'h7F, 8'h41);
    alu(csf_pkg::CSF_OP_SUB, 8'h80, 8'h01, 6'h04, 8'h7F, 8'h51);
    $display("test arith done");
  endtask : test_arith

  task automatic test_irq;
    @(posedge core_clk);
    fastIrqEnter <= 1'b1;
    @(posedge core_clk);
    fastIrqEnter <= 1'b0;
    #1;
    `CHK(flags, 8'h53);
    wr(csf_pkg::FLAGS_ADDR, 8'h00);
    `CHK(flags, 8'h02);
    @(posedge core_clk);
    irqReturnStart <= 1'b1;
    @(posedge core_clk);
    irqReturnStart <= 1'b0;
    #1;
    `CHK(flags, 8'h00);
    $display("test irq done");
  endtask : test_irq

  task automatic test_ops;
    alu(csf_pkg::CSF_OP_OR,   8'h80, 8'h01, 6'h3F, 8'h81, 8'h20);
    alu(csf_pkg::CSF_OP_XOR,  8'hAA, 8'hAA, 6'h3F, 8'h00, 8'h40);
    alu(csf_pkg::CSF_OP_PASS, 8'h80, 8'h55, 6'h3F, 8'h80, 8'h20);
    alu(csf_pkg::CSF_OP_ADD,  8'hFF, 8'h02, 6'h3F, 8'h01, 8'h84);
    alu(csf_pkg::CSF_OP_SBC,  8'h10, 8'h01, 6'h3F, 8'h0E, 8'h0C);
    $display("test ops done");
  endtask : test_ops

  task automatic test_collide;
    @(posedge core_clk);
    regAddr        <= csf_pkg::FLAGS_ADDR;
    regWrData      <= 8'hA0;
    regWr          <= 1'b1;
    regRd          <= 1'b1;
    aluOp          <= csf_pkg::CSF_OP_ADD;
    aluA           <= 8'h01;
    aluB           <= 8'h02;
    aluAffect      <= 6'h3F;
    aluValid       <= 1'b1;
    fastIrqEnter   <= 1'b1;
    irqReturnStart <= 1'b1;
    @(posedge core_clk);
    regWr          <= 1'b0;
    regRd          <= 1'b0;
    aluValid       <= 1'b0;
    fastIrqEnter   <= 1'b0;
    irqReturnStart <= 1'b0;
    #1;
    `CHK(regRdData, 8'h0C);
    `CHK(flags, 8'hA2);
    `CHK({7'h00, flags[1]}, 8'h01);
    `CHK(aluResult, 8'h03);
    $display("test collide done");
  endtask : test_collide

  task automatic test_reset;
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    `CHK(flags, csf_pkg::FLAGS_RESET);
    `CHK(regRdData, csf_pkg::RD_UNMAPPED);
    `CHK(aluResult, 8'h00);
    rd(csf_pkg::FLAGS_ADDR, csf_pkg::FLAGS_RESET);
    $display("test reset done");
  endtask : test_reset

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset, sequence, watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    #100000;
    fails++;
    finish_test();
  end

  initial
  begin
    fails = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    regAddr = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWrData = 8'h00;
    aluValid = 1'b0;
    aluOp = csf_pkg::CSF_OP_ADD;
    aluA = 8'h00;
    aluB = 8'h00;
    aluAffect = 6'h00;
    fastIrqEnter = 1'b0;
    irqReturnStart = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    test_regs();
    test_arith();
    test_irq();
    test_ops();
    test_collide();
    test_reset();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
